// *** rtl/spc_pkg.sv ***
/*
 * Constants and carrier types for the serial converter framing and
 * power-mode logic. Assumes a 10 MHz system clock sampling the serial pins.
 */
// Overview of operation
// - Mode chosen only by where select rises within a conversion frame.
// - Select falling samples the input; it starts a conversion in normal mode only.
// - Normal mode, rise between edges 10 and 16: stay powered, abort, release output.
// - Normal mode, rise between edges 2 and 10: partial power-down.
// - Normal mode, rise before edge 2: stay normal, glitch rejected.
// - Dummy conversion holding select past edge 10 wakes partial power-down.
// - Powered once select rises past edge 10 of dummy; only the next conversion is valid.
// - Partial power-down, rise before edge 2: back to partial power-down.
// - Partial power-down, rise between edges 2 and 10: full power-down.
// - On wake, track-and-hold returns to track at first clock edge.
// - Result word: four zeros then twelve result bits, MSB first.
// - Select falling holds the sample and drives the serial output.
// - Full power-down left by dummy held past edge 10; longer wake.
package spc_pkg;
    localparam int          SPC_RES_BITS   = 12;
    localparam int          SPC_WORD_BITS  = 16;
    localparam int          SPC_LEAD_ZEROS = 4;
    localparam logic [4:0]  SPC_EDGE_LOW   = 5'h02;
    localparam logic [4:0]  SPC_EDGE_HIGH  = 5'h0A;
    localparam logic [4:0]  SPC_EDGE_FULL  = 5'h10;
    localparam int          SPC_FIFO_DEPTH = 16;
    // full wake time in microseconds and in system clocks
    localparam int          SPC_FULL_WAKE_US = 650;
    localparam int          SPC_CLK_MHZ      = 10;
    localparam int          SPC_FULL_WAKE_CYC = SPC_FULL_WAKE_US * SPC_CLK_MHZ;

    typedef enum logic [1:0] {
        SPC_NORMAL  = 2'b00,
        SPC_PARTIAL = 2'b01,
        SPC_FULL    = 2'b10
    } spc_mode_e;

    typedef struct packed {
        logic [SPC_RES_BITS-1:0] data;
        logic                    valid_conv;
    } spc_sample_s;
endpackage

// *** rtl/spc_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module spc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    // wrapping pointers only serve power-of-two depths
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("spc_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_d;
    logic             in_ready_q;
    logic             push;
    logic             pop;

    // ready from a flop so the top output stays registered
    assign o_in_ready  = in_ready_q;
    assign o_out_valid = wr_q != rd_q;
    assign o_out_data  = mem_q[rd_q[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign wr_d        = push ? wr_q + 1'b1 : wr_q;
    assign rd_d        = pop ? rd_q + 1'b1 : rd_q;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q       <= '0;
            rd_q       <= '0;
            in_ready_q <= 1'b1;
        end else begin
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            in_ready_q <= (wr_d - rd_d) != (AW+1)'(DEPTH);
        end
    end
endmodule

// *** rtl/spc_top.sv ***
/*
 * Conversion framing and power-mode control of a 12-bit serial converter.
 * Assumes the serial master drives select and the serial clock slower
 * than a quarter of i_clk_sys; both are synchronised here.
 */
`timescale 1ns/1ps
module spc_top
    import spc_pkg::*;
#(
    parameter int FULL_WAKE_CYC = SPC_FULL_WAKE_CYC,
    parameter int FIFO_DEPTH    = SPC_FIFO_DEPTH
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_nrst,
    input  wire logic                    i_sel_n,
    input  wire logic                    i_sclk,
    input  wire logic                    i_sample_valid,
    input  wire logic [SPC_RES_BITS-1:0] i_sample_data,
    output logic                         o_sample_ready,
    output logic                         o_serial_out,
    output logic                         o_serial_out_oe,
    output logic [1:0]                   o_mode,
    output logic                         o_powered,
    output logic                         o_hold,
    output logic                         o_conv_start
);
    if (FULL_WAKE_CYC < 1 || FIFO_DEPTH < 2) begin
        $error("spc_top parameters out of range");
    end

    localparam int SW = $bits(spc_sample_s);
    localparam int WC = $clog2(FULL_WAKE_CYC + 1);

    logic [1:0]        sel_sync_q;
    logic [1:0]        sclk_sync_q;
    logic              sel_q;
    logic              sclk_q;
    logic              sel_fall;
    logic              sel_rise;
    logic              sclk_fall;
    logic              sclk_rise;
    logic              in_frame_q;
    logic [4:0]        edges_q;
    logic [4:0]        edges_d;
    spc_mode_e         mode_q;
    spc_mode_e         mode_d;
    logic              waking_q;
    logic              full_wake_q;
    logic [WC-1:0]     wake_cnt_q;
    logic              next_valid_q;
    logic [SPC_WORD_BITS-1:0] shift_q;
    logic [SPC_WORD_BITS-1:0] word_d;
    spc_sample_s       fifo_out;
    logic              fifo_valid;
    logic              fifo_pop;
    logic              out_active_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_sync_q  <= 2'h3;
            // link clock idles high: no false edge after reset
            sclk_sync_q <= 2'h3;
            sel_q       <= 1'b1;
            sclk_q      <= 1'b1;
        end else begin
            sel_sync_q  <= {sel_sync_q[0], i_sel_n};
            sclk_sync_q <= {sclk_sync_q[0], i_sclk};
            sel_q       <= sel_sync_q[1];
            sclk_q      <= sclk_sync_q[1];
        end
    end

    assign sel_fall  = sel_q && !sel_sync_q[1];
    assign sel_rise  = !sel_q && sel_sync_q[1];
    assign sclk_fall = sclk_q && !sclk_sync_q[1] && in_frame_q;
    assign sclk_rise = !sclk_q && sclk_sync_q[1] && in_frame_q;

    // count saturates at 16 so late edges change nothing
    always_comb begin
        edges_d = edges_q;
        if (sel_fall) begin
            edges_d = 5'h00;
        end else if (sclk_fall && edges_q != SPC_EDGE_FULL) begin
            edges_d = edges_q + 5'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            edges_q    <= 5'h00;
            in_frame_q <= 1'b0;
        end else begin
            edges_q <= edges_d;
            if (sel_fall) begin
                in_frame_q <= 1'b1;
            end else if (sel_rise) begin
                in_frame_q <= 1'b0;
            end
        end
    end

    // mode decided by the count at select rise
    always_comb begin
        mode_d = mode_q;
        if (sel_rise) begin
            if (edges_q < SPC_EDGE_LOW) begin
                // glitch: normal stays normal, low-power drops back
                mode_d = mode_q;
            end else if (edges_q < SPC_EDGE_HIGH) begin
                unique case (mode_q)
                    SPC_NORMAL:  mode_d = SPC_PARTIAL;
                    SPC_PARTIAL: mode_d = SPC_FULL;
                    SPC_FULL:    mode_d = SPC_FULL;
                    default:     mode_d = SPC_FULL;
                endcase
            end else begin
                // full wake leaves power-down here; o_powered waits
                mode_d = SPC_NORMAL;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= SPC_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // power-up tracking; a full wake runs a long timer
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            waking_q     <= 1'b0;
            full_wake_q  <= 1'b0;
            wake_cnt_q   <= '0;
            next_valid_q <= 1'b1;
        end else begin
            if (sel_fall && mode_q != SPC_NORMAL) begin
                waking_q     <= 1'b1;
                next_valid_q <= 1'b0;
            end else if (sel_rise) begin
                waking_q <= 1'b0;
            end else if (waking_q && edges_q == SPC_EDGE_FULL) begin
                // full wake too, else its timer never lets go
                waking_q <= 1'b0;
            end
            if (sel_fall && mode_q == SPC_FULL) begin
                full_wake_q <= 1'b1;
                wake_cnt_q  <= WC'(FULL_WAKE_CYC);
            end else if (full_wake_q && wake_cnt_q != '0) begin
                wake_cnt_q <= wake_cnt_q - 1'b1;
            end else if (full_wake_q && !waking_q) begin
                full_wake_q <= 1'b0;
            end
            if (sel_rise && mode_d == SPC_NORMAL && mode_q != SPC_NORMAL) begin
                next_valid_q <= 1'b1;
            end
        end
    end

    // hold on select fall, back to track at first clock edge on wake
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hold       <= 1'b0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= sel_fall && mode_q == SPC_NORMAL;
            if (sel_fall) begin
                o_hold <= 1'b1;
            end else if (waking_q && (sclk_fall || sclk_rise)) begin
                o_hold <= 1'b0;
            end else if (sel_rise || edges_q == SPC_EDGE_FULL) begin
                o_hold <= 1'b0;
            end
        end
    end

    // converted samples arrive here; stalls back-pressure the core
    assign fifo_pop = sel_fall && mode_q == SPC_NORMAL && !waking_q;

    // empty fifo or dummy frame gives zeros
    assign word_d = (fifo_valid && fifo_pop && next_valid_q &&
                     fifo_out.valid_conv) ?
                    {{SPC_LEAD_ZEROS{1'b0}}, fifo_out.data} :
                    {SPC_WORD_BITS{1'b0}};

    spc_fifo #(
        .WIDTH (SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_in_valid  (i_sample_valid),
        .o_in_ready  (o_sample_ready),
        .i_in_data   ({i_sample_data, 1'b1}),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out)
    );

    // shift register: four zeros then result, msb first
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_q         <= 16'h0000;
            out_active_q    <= 1'b0;
            o_serial_out    <= 1'b0;
            o_serial_out_oe <= 1'b0;
        end else begin
            if (sel_fall) begin
                // first bit stands from select fall, so bit 0 is
                // still on the line before the 16th fall releases it
                shift_q         <= {word_d[SPC_WORD_BITS-2:0], 1'b0};
                out_active_q    <= 1'b1;
                o_serial_out_oe <= 1'b1;
                o_serial_out    <= word_d[SPC_WORD_BITS-1];
            end else if (sel_rise || (out_active_q &&
                         edges_q == SPC_EDGE_FULL)) begin
                out_active_q    <= 1'b0;
                o_serial_out_oe <= 1'b0;
                o_serial_out    <= 1'b0;
            end else if (out_active_q && sclk_fall) begin
                o_serial_out <= shift_q[SPC_WORD_BITS-1];
                shift_q      <= {shift_q[SPC_WORD_BITS-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mode    <= 2'b00;
            o_powered <= 1'b1;
        end else begin
            o_mode    <= mode_q;
            o_powered <= mode_q == SPC_NORMAL && !full_wake_q;
        end
    end
endmodule

// *** testbench/spc_chk.sv ***
/* concurrent checks on the ports of spc_top
   assumes one 10 MHz clock and the active-low asynchronous reset */
`timescale 1ns/1ps
module spc_chk
    import spc_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    input wire logic        i_sel_n,
    input wire logic        i_sclk,
    input wire logic        i_sample_valid,
    input wire logic [11:0] i_sample_data,
    input wire logic        o_sample_ready,
    input wire logic        o_serial_out,
    input wire logic        o_serial_out_oe,
    input wire logic [1:0]  o_mode,
    input wire logic        o_powered,
    input wire logic        o_hold,
    input wire logic        o_conv_start
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // pins pass two sync flops, so answers land a few cycles late
    AST_HOLD_ON_SEL: assert property (
        $fell(i_sel_n) && o_powered |-> ##[2:5] o_hold && o_serial_out_oe)
        else $error("no hold or drive after select fall");
    AST_CONV_START: assert property (
        $fell(i_sel_n) && o_mode == SPC_NORMAL |-> ##[2:5] o_conv_start)
        else $error("no start pulse after select fall");
    AST_START_PULSE: assert property (
        o_conv_start |-> !i_sel_n ##1 !o_conv_start)
        else $error("start pulse too long or without select");
    AST_RELEASE: assert property (
        $rose(i_sel_n) |-> ##[2:5] !o_serial_out_oe)
        else $error("serial output not released");
    AST_MODE_HELD: assert property (
        (!i_sel_n) [*4] |-> $stable(o_mode))
        else $error("mode moved while select low");
    AST_NOT_POWERED: assert property (
        o_mode != SPC_NORMAL |-> !o_powered)
        else $error("powered flag set in power-down");
    AST_TRACK: assert property (
        o_hold && o_mode == SPC_PARTIAL && $fell(i_sclk) |-> ##[2:5] !o_hold)
        else $error("hold kept after first link clock edge");
    AST_IDLE_QUIET: assert property (
        i_sel_n [*8] |-> !o_serial_out_oe && !o_conv_start)
        else $error("activity while select idles high");
endmodule
bind spc_top spc_chk i_spc_chk (.*);

// *** testbench/spc_master.sv ***
/* serial master model driving select and the link clock
   assumes a 100 ns system clock; link clock period is 8 cycles */
`timescale 1ns/1ps
module spc_master (
    input  wire logic i_clk_sys,
    input  wire logic i_serial_out,
    output logic      o_sel_n,
    output logic      o_sclk
);
    initial begin
        o_sel_n = 1'b1; // idles high between frames
        o_sclk = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // n link clock falls; clock stands high outside the frame
    task automatic frame(input int n, output logic [15:0] w);
        w = 16'h0000;
        wt(1);
        o_sel_n = 1'b0;
        wt(8);
        for (int k = 0; k < n; k++) begin
            // a bit stands from the previous fall; read it before this one
            w = {w[14:0], i_serial_out};
            o_sclk = 1'b0;
            wt(4);
            o_sclk = 1'b1;
            wt(4);
        end
        o_sel_n = 1'b1; // n below 16 cuts the frame
        wt(12); // quiet interval
    endtask
endmodule

// *** testbench/tb_top.sv ***
/* self-checking bench for spc_top with the serial master model
   assumes the package, fifo and top module are compiled first */
`timescale 1ns/1ps
module tb_top
    import spc_pkg::*;
;
    logic        clk, nrst, sel_n, sclk, sv, rdy, so, oe, pw, hold, cs;
    logic        line;
    logic [11:0] sd;
    logic [1:0]  mode;
    logic [15:0] w;
    int          err_count, n_checks;
    // released line reads high, as with a pull-up
    assign line = oe ? so : 1'b1;
    spc_top #(.FULL_WAKE_CYC(20), .FIFO_DEPTH(16)) i_spc_top (
        .i_clk_sys      (clk),
        .i_nrst         (nrst),
        .i_sel_n        (sel_n),
        .i_sclk         (sclk),
        .i_sample_valid (sv),
        .i_sample_data  (sd),
        .o_sample_ready (rdy),
        .o_serial_out   (so),
        .o_serial_out_oe(oe),
        .o_mode         (mode),
        .o_powered      (pw),
        .o_hold         (hold),
        .o_conv_start   (cs)
    );
    spc_master i_spc_master (
        .i_clk_sys   (clk),
        .i_serial_out(line),
        .o_sel_n     (sel_n),
        .o_sclk      (sclk)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // holds valid up across calls; caller lowers it afterwards
    task automatic push(input logic [11:0] d, input logic r);
        chk(16'(rdy), 16'(r));
        sv = 1'b1;
        sd = d;
        @(negedge clk);
    endtask
    task automatic mf(input int n, input spc_mode_e m);
        i_spc_master.frame(n, w);
        chk(16'(mode), 16'(m));
        chk(16'(oe), 16'h0000);
        chk(16'(pw), 16'(m == SPC_NORMAL));
    endtask
    // fill until refused, then drain through full frames in order
    task automatic t_fifo();
        for (int i = 0; i < 16; i++) begin
            push(12'h8C3 ^ (12'h111 * 12'(i)), 1'b1);
        end
        push(12'hFFF, 1'b0);
        sv = 1'b0;
        for (int i = 0; i < 16; i++) begin
            i_spc_master.frame(16, w);
            chk(w, {4'h0, 12'h8C3 ^ (12'h111 * 12'(i))});
        end
        mf(16, SPC_NORMAL);
        chk(w, 16'h0000); // empty buffer gives zeros
    endtask
    task automatic t_modes();
        mf(1, SPC_NORMAL);
        mf(12, SPC_NORMAL);
        mf(2, SPC_PARTIAL);
        mf(1, SPC_PARTIAL);
        push(12'h5A7, 1'b1);
        sv = 1'b0;
        mf(16, SPC_NORMAL);
        chk(w, 16'h0000);
        chk(16'(pw), 16'h0001);
        mf(16, SPC_NORMAL);
        chk(w, 16'h05A7);
        mf(3, SPC_PARTIAL);
        mf(12, SPC_NORMAL);
        mf(9, SPC_PARTIAL);
        mf(5, SPC_FULL);
        mf(16, SPC_NORMAL);
        chk(16'(pw), 16'h0001);
        push(12'h3C1, 1'b1);
        sv = 1'b0;
        // wait out the full-wake timer before a real conversion
        repeat (20) @(negedge clk);
        mf(16, SPC_NORMAL);
        chk(w, 16'h03C1);
    endtask
    initial begin
        err_count = 0;
        n_checks = 0;
        nrst = 1'b0;
        sv = 1'b0;
        sd = 12'h000;
        repeat (16) @(negedge clk);
        chk(16'({mode, pw, hold, oe, rdy}), 16'h0009); // reset values
        nrst = 1'b1;
        t_fifo();
        t_modes();
        end_sim();
    end
endmodule
